// ==== pmc_pkg.sv ====
package pmc_pkg;
	// register byte offsets, bus address is adr_i[4:0], word index adr_i[4:2]
	localparam logic [4:0] OFF_PCR = 5'h00;
	localparam logic [4:0] OFF_MON = 5'h04;
	localparam logic [4:0] OFF_STAT = 5'h08;
	localparam logic [4:0] OFF_MASK = 5'h0c;
	localparam logic [4:0] OFF_STATE = 5'h10;

	// power_control_register fields
	localparam int B_HALT = 0;
	localparam int B_SLEEP = 1;
	localparam int B_HOLD = 2;
	localparam int B_MPWR = 3;
	localparam int B_MCONV = 4;
	localparam int B_LOCK = 5;
	localparam int B_HALVE = 6;

	// monitor register fields
	localparam int B_START = 0;
	localparam int B_RERR = 1;
	localparam int B_CODE_LO = 8;
	localparam int CODE_W = 5;

	// interrupt status / mask fields
	localparam int B_EV_DONE = 0;
	localparam int B_EV_RERR = 1;
	localparam int B_EV_WAKE = 2;
	localparam int EV_W = 3;

	// converter state register fields
	localparam int B_ST_RUN = 0;
	localparam int B_ST_3V = 1;
	localparam int B_ST_BTN = 2;

	// battery monitor conversion
	localparam int CONV_CYCLES = 34;
	localparam int MV_W = 12;
	localparam logic [MV_W-1:0] MV_MIN = 12'h384;
	localparam logic [MV_W-1:0] MV_END = 12'h6d6;
	localparam logic [MV_W-1:0] MV_STEP = 12'h032;
	localparam logic [CODE_W-1:0] CODE_MAX = 5'h1f;

	localparam logic [6:0] PCR_RESET = 7'h00;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

	typedef enum logic [0:0] {
		CONV_IDLE,
		CONV_RUN
	} pmc_conv_state_type;
endpackage : pmc_pkg

// ==== pmc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule : pmc_sync2
`default_nettype wire

// ==== pmc_vbat_conv.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_vbat_conv (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [pmc_pkg::MV_W-1:0] battery_mv_i,
	output logic busy_o,
	output logic done_o,
	output logic range_error_o,
	output logic [pmc_pkg::CODE_W-1:0] code_o
);
	pmc_pkg::pmc_conv_state_type state_ff;
	logic [5:0] cnt_ff;
	logic [pmc_pkg::MV_W-1:0] mv_ff;
	logic [pmc_pkg::MV_W-1:0] resid_ff;
	logic [pmc_pkg::CODE_W-1:0] steps_ff;
	logic done_ff;
	logic err_ff;
	logic [pmc_pkg::CODE_W-1:0] code_ff;

	wire logic last = (cnt_ff == 6'(pmc_pkg::CONV_CYCLES - 1));
	wire logic in_range = (mv_ff >= pmc_pkg::MV_MIN) && (mv_ff < pmc_pkg::MV_END);
	wire logic can_step = (resid_ff >= pmc_pkg::MV_STEP) && (steps_ff != pmc_pkg::CODE_MAX);

	// quantisation by repeated subtraction, at most 31 steps (CODE_MAX) inside the 34 cycles
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= pmc_pkg::CONV_IDLE;
			cnt_ff <= '0;
			mv_ff <= '0;
			resid_ff <= '0;
			steps_ff <= '0;
			done_ff <= 1'b0;
			err_ff <= 1'b0;
			code_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			unique case (state_ff)
				pmc_pkg::CONV_IDLE: begin
					if (start_i) begin
						state_ff <= pmc_pkg::CONV_RUN;
						cnt_ff <= '0;
						mv_ff <= battery_mv_i;
						resid_ff <= battery_mv_i - pmc_pkg::MV_MIN;
						steps_ff <= '0;
					end
				end
				pmc_pkg::CONV_RUN: begin
					cnt_ff <= cnt_ff + 6'h01;
					if (can_step) begin
						resid_ff <= resid_ff - pmc_pkg::MV_STEP; // [R6]
						steps_ff <= steps_ff + 5'h01; // [R7]
					end
					if (last) begin
						state_ff <= pmc_pkg::CONV_IDLE; // [R10]
						done_ff <= 1'b1;
						err_ff <= !in_range; // [R11] [R12]
						if (in_range) begin
							code_ff <= steps_ff; // [R11]
						end
					end
				end
			endcase
		end
	end

	assign busy_o = (state_ff == pmc_pkg::CONV_RUN);
	assign done_o = done_ff;
	assign range_error_o = err_ff;
	assign code_o = code_ff;

	// the counter only advances while running, so checking both end points covers the whole span
	a_conv_length: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R10]
		(state_ff == pmc_pkg::CONV_IDLE && start_i) |=> (busy_o && cnt_ff == 6'h00) ##33 (busy_o && last)
		##1 !busy_o)
		else $error("conversion did not last 34 cycles");

	a_code_in_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R7]
		(busy_o && last && in_range) |=> !range_error_o
		&& (mv_ff >= pmc_pkg::MV_MIN + 12'(code_o) * pmc_pkg::MV_STEP)
		&& (mv_ff < pmc_pkg::MV_MIN + 12'(code_o) * pmc_pkg::MV_STEP + pmc_pkg::MV_STEP))
		else $error("code does not match battery voltage");

	a_err_out_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R12]
		(busy_o && last && !in_range) |=> range_error_o && done_o)
		else $error("range error not flagged");
endmodule : pmc_vbat_conv
`default_nettype wire

// ==== pmc_power_ctrl.sv ====
// Overview of operation
// R1: pressing the start button (low) starts the converter; holder keeps it until enabled.
// R2: with hold-on set, converter stays running after the button is released.
// R3: clearing hold-on while the button is released shuts the converter down.
// R4: a detected 3V supply disables the converter to save the battery.
// R5: hold-on still set when 3V supply goes away restarts the converter at once.
// R6: battery monitor yields a 5-bit code in 50 mV steps.
// R7: code 0 is 0.9 to 0.95 V, code 16 is 1.7 to 1.75 V.
// R8: software sets monitor power, then monitor converter enable 1 ms later.
// R9: software waits 16 more cycles before starting a conversion.
// R10: writing start begins a 34-cycle conversion; start clears itself at the end.
// R11: in range: range error cleared and code loaded.
// R12: out of range: range error set, code undefined.
// R13: while locked, writes setting halt or deep sleep have no effect.
// R14: software sets the lock in event handlers and clears it after wake.
// R15: clock halving mode divides core and peripheral clocks by two.
// R16: halt and deep sleep written together enter deep sleep, never idle after.
// R17: an enabled interrupt during idle clears halt and restores the cpu clock.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic converter_start_button_n_i,
	input wire logic supply_3v_detect_i,
	input wire logic [pmc_pkg::MV_W-1:0] battery_mv_i,
	input wire logic wake_irq_i,
	output logic converter_enable_o,
	output logic monitor_power_enable_o,
	output logic monitor_converter_enable_o,
	output logic cpu_clock_halt_o,
	output logic deep_sleep_o,
	output logic clock_halving_mode_o,
	output logic clock_half_enable_o,
	output logic irq_o
);
	// control bits
	logic cpu_halt_request_ff;
	logic deep_sleep_request_ff;
	logic converter_hold_on_ff;
	logic monitor_power_enable_ff;
	logic monitor_converter_enable_ff;
	logic power_reduction_lock_ff;
	logic clock_halving_mode_ff;
	logic [pmc_pkg::EV_W-1:0] status_ff;
	logic [pmc_pkg::EV_W-1:0] mask_ff;

	// bus and output flops
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic converter_enable_ff;
	logic half_phase_ff;
	logic irq_ff;

	// synchronised pins; the button is inverted first so that the cleared
	// synchroniser reads as released and no false press follows reset
	logic [1:0] pins_sync;
	wire logic button_pressed = pins_sync[0];
	wire logic supply_3v_present = pins_sync[1];

	pmc_sync2 #(
		.W(2)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.async_i({supply_3v_detect_i, !converter_start_button_n_i}),
		.sync_o(pins_sync)
	);

	// bus decode
	wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	wire logic bus_wr = bus_req && wb_we_i;
	wire logic [2:0] word_idx = wb_adr_i[4:2];
	wire logic hit_pcr = (word_idx == pmc_pkg::OFF_PCR[4:2]);
	wire logic hit_mon = (word_idx == pmc_pkg::OFF_MON[4:2]);
	wire logic hit_stat = (word_idx == pmc_pkg::OFF_STAT[4:2]);
	wire logic hit_mask = (word_idx == pmc_pkg::OFF_MASK[4:2]);
	wire logic hit_state = (word_idx == pmc_pkg::OFF_STATE[4:2]);
	wire logic wr_lane0 = bus_wr && wb_sel_i[0];
	wire logic wr_pcr = wr_lane0 && hit_pcr;
	wire logic wr_mon = wr_lane0 && hit_mon;
	wire logic wr_stat = wr_lane0 && hit_stat;
	wire logic wr_mask = wr_lane0 && hit_mask;

	// monitor conversion engine
	logic conv_busy;
	logic conv_done;
	logic conv_err;
	logic [pmc_pkg::CODE_W-1:0] conv_code;
	wire logic conv_start = wr_mon && wb_dat_i[pmc_pkg::B_START] && !conv_busy; // [R10]

	pmc_vbat_conv u_conv (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.start_i(conv_start),
		.battery_mv_i(battery_mv_i),
		.busy_o(conv_busy),
		.done_o(conv_done),
		.range_error_o(conv_err),
		.code_o(conv_code)
	);

	// power reduction requests
	wire logic req_halt = wr_pcr && wb_dat_i[pmc_pkg::B_HALT];
	wire logic req_sleep = wr_pcr && wb_dat_i[pmc_pkg::B_SLEEP];
	wire logic entry_allowed = !power_reduction_lock_ff; // [R13]
	wire logic wake = wake_irq_i && (cpu_halt_request_ff || deep_sleep_request_ff);
	// both together means deep sleep only, so no idle follows the wake
	wire logic set_sleep = req_sleep && entry_allowed; // [R16]
	wire logic set_halt = req_halt && !req_sleep && entry_allowed; // [R13] [R16]

	logic nxt_cpu_halt_request;
	logic nxt_deep_sleep_request;
	always_comb begin
		nxt_cpu_halt_request = cpu_halt_request_ff;
		nxt_deep_sleep_request = deep_sleep_request_ff;
		if (set_halt) begin
			nxt_cpu_halt_request = 1'b1;
		end
		if (set_sleep) begin
			nxt_deep_sleep_request = 1'b1;
		end
		if (wake) begin
			nxt_cpu_halt_request = 1'b0; // [R17]
			nxt_deep_sleep_request = 1'b0;
		end
	end

	// converter: button starts it, hold-on keeps it, 3V supply overrides both
	wire logic nxt_converter_enable = !supply_3v_present
		&& (button_pressed || converter_hold_on_ff); // [R1] [R2] [R3] [R4] [R5]

	// sticky events, a new event wins over a write-one clear
	wire logic [pmc_pkg::EV_W-1:0] ev_set = {wake, conv_done && conv_err, conv_done};
	wire logic [pmc_pkg::EV_W-1:0] ev_clr = wr_stat ? wb_dat_i[pmc_pkg::EV_W-1:0] : '0;
	wire logic [pmc_pkg::EV_W-1:0] nxt_status = (status_ff & ~ev_clr) | ev_set;

	// read data
	wire logic [31:0] rd_pcr = {25'h0000000, clock_halving_mode_ff, power_reduction_lock_ff,
		monitor_converter_enable_ff, monitor_power_enable_ff, converter_hold_on_ff,
		deep_sleep_request_ff, cpu_halt_request_ff};
	wire logic [31:0] rd_mon = {19'h00000, conv_code, 6'h00, conv_err, conv_busy};
	wire logic [31:0] rd_stat = {29'h00000000, status_ff};
	wire logic [31:0] rd_mask = {29'h00000000, mask_ff};
	wire logic [31:0] rd_state = {29'h00000000, button_pressed, supply_3v_present,
		converter_enable_ff};
	wire logic [31:0] rd_mux = hit_pcr ? rd_pcr :
		hit_mon ? rd_mon :
		hit_stat ? rd_stat :
		hit_mask ? rd_mask :
		hit_state ? rd_state : 32'h00000000;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else begin
			ack_ff <= bus_req;
			rdata_ff <= bus_req ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cpu_halt_request_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_HALT];
			deep_sleep_request_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_SLEEP];
		end else begin
			cpu_halt_request_ff <= nxt_cpu_halt_request;
			deep_sleep_request_ff <= nxt_deep_sleep_request;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			converter_hold_on_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_HOLD];
			monitor_power_enable_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_MPWR];
			monitor_converter_enable_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_MCONV];
			power_reduction_lock_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_LOCK];
			clock_halving_mode_ff <= pmc_pkg::PCR_RESET[pmc_pkg::B_HALVE];
		end else if (wr_pcr) begin
			converter_hold_on_ff <= wb_dat_i[pmc_pkg::B_HOLD];
			monitor_power_enable_ff <= wb_dat_i[pmc_pkg::B_MPWR];
			monitor_converter_enable_ff <= wb_dat_i[pmc_pkg::B_MCONV];
			power_reduction_lock_ff <= wb_dat_i[pmc_pkg::B_LOCK];
			clock_halving_mode_ff <= wb_dat_i[pmc_pkg::B_HALVE];
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_ff <= '0;
			mask_ff <= pmc_pkg::MASK_RESET;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			if (wr_mask) begin
				mask_ff <= wb_dat_i[pmc_pkg::EV_W-1:0];
			end
			irq_ff <= |(nxt_status & (wr_mask ? wb_dat_i[pmc_pkg::EV_W-1:0] : mask_ff));
		end
	end

	// half-rate enable toggles in halving mode, steady high otherwise
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			converter_enable_ff <= 1'b0;
			half_phase_ff <= 1'b1;
		end else begin
			converter_enable_ff <= nxt_converter_enable;
			half_phase_ff <= clock_halving_mode_ff ? !half_phase_ff : 1'b1; // [R15]
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign converter_enable_o = converter_enable_ff;
	assign monitor_power_enable_o = monitor_power_enable_ff;
	assign monitor_converter_enable_o = monitor_converter_enable_ff;
	assign cpu_clock_halt_o = cpu_halt_request_ff;
	assign deep_sleep_o = deep_sleep_request_ff;
	assign clock_halving_mode_o = clock_halving_mode_ff;
	assign clock_half_enable_o = half_phase_ff;
	assign irq_o = irq_ff;

	a_button_starts: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R1]
		(button_pressed && !supply_3v_present) |=> converter_enable_o)
		else $error("button did not start converter");

	a_hold_keeps_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
		(converter_hold_on_ff && !supply_3v_present) |=> converter_enable_o)
		else $error("hold-on did not keep converter running");

	a_hold_clear_stops: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R3]
		(!converter_hold_on_ff && !button_pressed) |=> !converter_enable_o)
		else $error("converter not shut down");

	a_3v_disables: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R4]
		supply_3v_present |=> !converter_enable_o)
		else $error("converter running with 3V supply");

	a_usb_gone_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
		($fell(supply_3v_present) && converter_hold_on_ff) |=> converter_enable_o)
		else $error("converter did not restart after 3V supply left");

	a_lock_blocks: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R13]
		(power_reduction_lock_ff && !cpu_halt_request_ff && !deep_sleep_request_ff)
		|=> !cpu_clock_halt_o && !deep_sleep_o)
		else $error("power reduction entered while locked");

	a_both_sleep_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R16]
		(req_halt && req_sleep && entry_allowed && !wake_irq_i && !cpu_halt_request_ff)
		|=> deep_sleep_o && !cpu_clock_halt_o)
		else $error("combined request entered idle");

	a_wake_clears: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R17]
		(cpu_halt_request_ff && wake_irq_i) |=> !cpu_clock_halt_o)
		else $error("interrupt did not end idle");

	// busy stands on edges 1 to 34 after the start, the done pulse on edge 35, the event on edge 36
	a_start_selfclear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R10]
		conv_start |=> conv_busy ##33 conv_busy ##1 (!rd_mon[pmc_pkg::B_START] && conv_done)
		##1 status_ff[pmc_pkg::B_EV_DONE])
		else $error("start bit did not clear at end");

	a_halve_toggle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R15]
		(clock_halving_mode_ff && $past(clock_halving_mode_ff)) |-> (half_phase_ff != $past(half_phase_ff)))
		else $error("halving enable not toggling");

	a_halve_steady: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R15]
		!clock_halving_mode_ff |=> clock_half_enable_o)
		else $error("half enable not steady outside halving mode");

	a_mode_written: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R15]
		wr_pcr |=> (clock_halving_mode_o == $past(wb_dat_i[pmc_pkg::B_HALVE])))
		else $error("halving mode bit not stored");

	a_hold_written: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
		wr_pcr |=> (converter_hold_on_ff == $past(wb_dat_i[pmc_pkg::B_HOLD])))
		else $error("hold-on bit not stored");

	a_mon_written: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_pcr |=> (monitor_power_enable_o == $past(wb_dat_i[pmc_pkg::B_MPWR]))
		&& (monitor_converter_enable_o == $past(wb_dat_i[pmc_pkg::B_MCONV])))
		else $error("monitor enable bits not stored");

	a_halt_unlocked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R13]
		$rose(cpu_clock_halt_o) |-> !$past(power_reduction_lock_ff))
		else $error("idle entered while locked");

	a_sleep_unlocked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R13]
		$rose(deep_sleep_o) |-> !$past(power_reduction_lock_ff))
		else $error("deep sleep entered while locked");

	a_halt_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(cpu_halt_request_ff && !wake_irq_i) |=> cpu_clock_halt_o)
		else $error("idle left without interrupt");

	a_sleep_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(deep_sleep_request_ff && !wake_irq_i) |=> deep_sleep_o)
		else $error("deep sleep left without interrupt");

	a_sleep_wake: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R16]
		(deep_sleep_request_ff && wake_irq_i) |=> !deep_sleep_o && !cpu_clock_halt_o)
		else $error("wake from deep sleep entered idle");

	a_wake_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R17]
		wake |=> status_ff[pmc_pkg::B_EV_WAKE])
		else $error("wake event not recorded");

	a_done_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R10]
		conv_done |=> status_ff[pmc_pkg::B_EV_DONE])
		else $error("conversion done event not recorded");

	a_err_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R12]
		(conv_done && conv_err) |=> status_ff[pmc_pkg::B_EV_RERR])
		else $error("range error event not recorded");

	a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(status_ff[pmc_pkg::B_EV_DONE] && !wr_stat) |=> status_ff[pmc_pkg::B_EV_DONE])
		else $error("status bit lost without clear");

	a_ack_single: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus acknowledge longer than one cycle");

	a_rdata_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!wb_ack_o |-> (wb_dat_o == 32'h00000000))
		else $error("read data not zero outside acknowledge");

	a_state_readback: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(bus_req && !wb_we_i && hit_state) |=> (wb_dat_o[pmc_pkg::B_ST_RUN] == $past(converter_enable_ff)))
		else $error("state read does not show converter enable");

	a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!(|(status_ff & mask_ff)) |-> !irq_o)
		else $error("interrupt high with nothing unmasked");

	a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(|(status_ff & mask_ff)) |-> irq_o)
		else $error("interrupt low with unmasked status");
endmodule : pmc_power_ctrl
`default_nettype wire

// ==== pmc_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_far_side (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic press_i,
	input wire logic usb_i,
	input wire logic converter_enable_i,
	input wire logic hold_latched_i,
	output logic button_n_o,
	output logic supply_3v_o
);
	// pulled-up button: held down until the converter runs and hold-on is latched
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			button_n_o <= 1'b1;
			supply_3v_o <= 1'b0;
		end else begin
			if (press_i)
				button_n_o <= 1'b0;
			else if (converter_enable_i && hold_latched_i)
				button_n_o <= 1'b1;
			supply_3v_o <= usb_i;
		end
	end
endmodule : pmc_far_side
`default_nettype wire

// ==== pmc_power_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl_tb;
	localparam int MON_SETTLE = 1000;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic press = 1'b0;
	logic usb = 1'b0;
	logic hold_latched = 1'b0;
	logic wake = 1'b0;
	logic [11:0] mv = 12'h000;
	logic button_n, supply_3v, conv_en, mon_pwr, mon_conv, halt, sleep, halving, half_en, irq;
	logic [31:0] rd;
	int fails = 0;
	int samples_checked = 0;
	int mv_tab [8] = '{900, 949, 950, 1234, 1700, 1749, 1750, 899};

	always #2 clk_sys = ~clk_sys;

	pmc_far_side i_far (.clk_sys_i(clk_sys), .resetn_i(resetn), .press_i(press), .usb_i(usb),
		.converter_enable_i(conv_en), .hold_latched_i(hold_latched), .button_n_o(button_n),
		.supply_3v_o(supply_3v));

	pmc_power_ctrl i_dut (.clk_sys_i(clk_sys), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.converter_start_button_n_i(button_n), .supply_3v_detect_i(supply_3v), .battery_mv_i(mv),
		.wake_irq_i(wake), .converter_enable_o(conv_en), .monitor_power_enable_o(mon_pwr),
		.monitor_converter_enable_o(mon_conv), .cpu_clock_halt_o(halt), .deep_sleep_o(sleep),
		.clock_halving_mode_o(halving), .clock_half_enable_o(half_en), .irq_o(irq));

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk_sys);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 50)
			chk("bus ack", 32'h1, 32'h0);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rchk

	task look(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : look

	task wake_pulse;
		@(posedge clk_sys);
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
	endtask : wake_pulse

	task wrap_up;
		$display("TB: checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clk_sys);
		chk("watchdog", 32'h0, 32'h1);
		wrap_up();
	end

	initial begin
		int n;
		int v;
		logic err;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		look(1);
		chk("half enable reset", 32'h1, {31'h0, half_en});
		chk("outputs reset", 32'h0, {25'h0, conv_en, mon_pwr, mon_conv, halt, sleep, halving, irq});
		rchk(pmc_pkg::OFF_PCR, {25'h0, pmc_pkg::PCR_RESET}, "pcr reset");
		rchk(pmc_pkg::OFF_MASK, {29'h0, pmc_pkg::MASK_RESET}, "mask reset");
		wb(1'b1, 5'h14, 32'h7f);
		rchk(5'h14, 32'h0, "unmapped read");
		rchk(pmc_pkg::OFF_PCR, 32'h0, "pcr after unmapped write");
		$display("TB: reset test done");

		press <= 1'b1;
		@(posedge clk_sys);
		press <= 1'b0;
		look(5);
		chk("converter on by button", 32'h1, {31'h0, conv_en});
		rchk(pmc_pkg::OFF_STATE, 32'h5, "state pressed");
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h4);
		hold_latched <= 1'b1;
		look(8);
		chk("button released", 32'h1, {31'h0, button_n});
		chk("converter held on", 32'h1, {31'h0, conv_en});
		@(posedge clk_sys);
		usb <= 1'b1;
		look(5);
		chk("converter off on 3v", 32'h0, {31'h0, conv_en});
		rchk(pmc_pkg::OFF_STATE, 32'h2, "state 3v");
		usb <= 1'b0;
		look(5);
		chk("converter restart", 32'h1, {31'h0, conv_en});
		@(posedge clk_sys);
		hold_latched <= 1'b0;
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h0);
		look(5);
		chk("converter shut down", 32'h0, {31'h0, conv_en});
		$display("TB: converter test done");

		wb(1'b1, pmc_pkg::OFF_PCR, 32'h08);
		look(1);
		chk("monitor power", 32'h1, {31'h0, mon_pwr});
		// settle shortened: the block does not time it
		repeat (MON_SETTLE) @(posedge clk_sys);
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h18);
		look(1);
		chk("monitor converter", 32'h1, {31'h0, mon_conv});
		repeat (16) @(posedge clk_sys);
		wb(1'b1, pmc_pkg::OFF_MASK, 32'h1);
		for (int k = 0; k < 9; k++) begin
			v = (k < 8) ? mv_tab[k] : 1000;
			err = (v < 900) || (v >= 1750);
			mv <= v[11:0];
			if (k == 8)
				wb(1'b1, pmc_pkg::OFF_MASK, 32'h0);
			wb(1'b1, pmc_pkg::OFF_MON, 32'h1);
			n = 1;
			@(negedge clk_sys);
			while (irq !== 1'b1 && n < 60) begin
				@(negedge clk_sys);
				n++;
			end
			if (k < 8)
				chk("conversion length ok", 32'h1, {31'h0, n == 34 || n == 35});
			else
				chk("masked irq", 32'h0, {31'h0, irq});
			@(posedge clk_sys);
			wb(1'b0, pmc_pkg::OFF_MON, 32'h0);
			if (err)
				chk("range error", 32'h2, rd & 32'h3);
			else
				chk("battery code", 32'((v - 900) / 50) << 8, rd);
			rchk(pmc_pkg::OFF_STAT, {30'h0, err, 1'b1}, "status events");
			wb(1'b1, pmc_pkg::OFF_STAT, 32'h7);
			look(1);
			chk("irq cleared", 32'h0, {31'h0, irq});
			rchk(pmc_pkg::OFF_STAT, 32'h0, "status cleared");
		end
		$display("TB: monitor test done");

		wb(1'b1, pmc_pkg::OFF_PCR, 32'h20);
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h23);
		look(1);
		chk("locked modes", 32'h0, {30'h0, halt, sleep});
		rchk(pmc_pkg::OFF_PCR, 32'h20, "locked pcr");
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h0);
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h1);
		look(1);
		chk("idle entered", 32'h2, {30'h0, halt, sleep});
		wake_pulse();
		look(2);
		chk("idle exit", 32'h0, {30'h0, halt, sleep});
		rchk(pmc_pkg::OFF_STAT, 32'h4, "wake event");
		wb(1'b1, pmc_pkg::OFF_STAT, 32'h7);
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h3);
		look(1);
		chk("deep sleep only", 32'h1, {30'h0, halt, sleep});
		wake_pulse();
		look(3);
		chk("no idle after wake", 32'h0, {30'h0, halt, sleep});
		$display("TB: lock test done");

		wb(1'b1, pmc_pkg::OFF_PCR, 32'h40);
		look(1);
		chk("halving mode", 32'h1, {31'h0, halving});
		rd = {31'h0, half_en};
		@(negedge clk_sys);
		chk("half enable toggles", ~rd & 32'h1, {31'h0, half_en});
		@(posedge clk_sys);
		wb(1'b1, pmc_pkg::OFF_PCR, 32'h0);
		look(2);
		chk("half enable steady", 32'h1, {31'h0, half_en});
		$display("TB: halving test done");
		wrap_up();
	end
endmodule : pmc_power_ctrl_tb
`default_nettype wire
